// [hdl/asq_map.svh]
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH

// Register addresses on the reconfiguration port
`define ASQ_CFG0_ADDR      7'h40
`define ASQ_THR_TEMP_ADDR  7'h50
`define ASQ_THR_VINT_ADDR  7'h51
`define ASQ_THR_VAUX_ADDR  7'h52
`define ASQ_THR_VBRAM_ADDR 7'h58
`define ASQ_STAT_TOP_ADDR  7'h1f

// Reset values
`define ASQ_CFG0_RST       16'h9000
`define ASQ_THR_TEMP_RST   16'hb5ed
`define ASQ_THR_VINT_RST   16'h5999
`define ASQ_THR_VAUX_RST   16'ha147
`define ASQ_THR_VBRAM_RST  16'h5999

// Averaging select field of configuration register 0
`define ASQ_AVG_HI_BIT     13
`define ASQ_AVG_LO_BIT     12
`define ASQ_AVG_OFF        2'h0

// Channel numbers
`define ASQ_CH_TEMP        5'h00
`define ASQ_CH_VINT        5'h01
`define ASQ_CH_VAUX        5'h02
`define ASQ_CH_VPN         5'h03
`define ASQ_CH_VBRAM       5'h06
`define ASQ_CH_CAL         5'h08
`define ASQ_CH_AUX0        5'h10
`define ASQ_CH_AUX1        5'h11
`define ASQ_CH_AUX2        5'h12
`define ASQ_CH_AUX3        5'h13

// Alarm bit positions
`define ASQ_ALM_TEMP       0
`define ASQ_ALM_VINT       1
`define ASQ_ALM_VAUX       2
`define ASQ_ALM_VBRAM      3

// Sequence and timing
`define ASQ_SEQ_LEN        10
`define ASQ_SEQ_LAST       4'h9
`define ASQ_CONV_CYCLES    26

`endif

// [hdl/asq_pkg.sv]
package asq_pkg;
  typedef logic [15:0] asq_word_t;
  typedef logic [4:0]  asq_chan_t;
  typedef logic [6:0]  asq_addr_t;
  typedef enum logic [1:0]
  {
    ST_CAL0 = 2'b00,
    ST_CAL1 = 2'b01,
    ST_CAL2 = 2'b10,
    ST_CONV = 2'b11
  } asq_state_t;
endpackage

// [hdl/asq_res_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface asq_res_if;
  import asq_pkg::*;
  logic            ld;
  asq_chan_t       ld_addr;
  asq_word_t       ld_data;
  logic [1:0]      cfg_avg;
  logic [3:0][15:0] thr;
  modport seq  (output ld, output ld_addr, output ld_data, input cfg_avg, input thr);
  modport regs (input ld, input ld_addr, input ld_data, output cfg_avg, output thr);
endinterface
`default_nettype wire

// [hdl/asq_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "asq_map.svh"
module asq_regs
(
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // Reconfiguration port
  input  wire logic         i_den,
  input  wire logic         i_dwe,
  input  wire asq_pkg::asq_addr_t i_daddr,
  input  wire asq_pkg::asq_word_t i_di,
  output var  asq_pkg::asq_word_t o_do,
  output var  logic         o_drdy,
  // Sequencer side
  asq_res_if.regs           res
);
  import asq_pkg::*;

  asq_word_t stat_r [0:31];
  asq_word_t cfg0_r;
  logic [3:0][15:0] thr_r;
  asq_word_t rd_nxt;

  assign res.cfg_avg = cfg0_r[`ASQ_AVG_HI_BIT:`ASQ_AVG_LO_BIT];
  assign res.thr     = thr_r;

  // Results land here at the end of each channel slot
  always_ff @(posedge i_mclk)
  begin
    if (res.ld)
      stat_r[res.ld_addr] <= res.ld_data; // [RULE9] [RULE10] [RULE11]
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      cfg0_r <= `ASQ_CFG0_RST;
      thr_r[`ASQ_ALM_TEMP]  <= `ASQ_THR_TEMP_RST;
      thr_r[`ASQ_ALM_VINT]  <= `ASQ_THR_VINT_RST;
      thr_r[`ASQ_ALM_VAUX]  <= `ASQ_THR_VAUX_RST;
      thr_r[`ASQ_ALM_VBRAM] <= `ASQ_THR_VBRAM_RST;
    end
    else if (i_den && i_dwe)
    begin
      unique case (i_daddr)
        `ASQ_CFG0_ADDR:      cfg0_r <= i_di; // [RULE5]
        `ASQ_THR_TEMP_ADDR:  thr_r[`ASQ_ALM_TEMP]  <= i_di;
        `ASQ_THR_VINT_ADDR:  thr_r[`ASQ_ALM_VINT]  <= i_di;
        `ASQ_THR_VAUX_ADDR:  thr_r[`ASQ_ALM_VAUX]  <= i_di;
        `ASQ_THR_VBRAM_ADDR: thr_r[`ASQ_ALM_VBRAM] <= i_di;
        default:             cfg0_r <= cfg0_r;
      endcase
    end
  end

  always_comb
  begin
    rd_nxt = 16'h0000;
    if (i_daddr <= `ASQ_STAT_TOP_ADDR)
      rd_nxt = stat_r[i_daddr[4:0]];
    else if (i_daddr == `ASQ_CFG0_ADDR)
      rd_nxt = cfg0_r;
    else if (i_daddr == `ASQ_THR_TEMP_ADDR)
      rd_nxt = thr_r[`ASQ_ALM_TEMP];
    else if (i_daddr == `ASQ_THR_VINT_ADDR)
      rd_nxt = thr_r[`ASQ_ALM_VINT];
    else if (i_daddr == `ASQ_THR_VAUX_ADDR)
      rd_nxt = thr_r[`ASQ_ALM_VAUX];
    else if (i_daddr == `ASQ_THR_VBRAM_ADDR)
      rd_nxt = thr_r[`ASQ_ALM_VBRAM];
  end

  // One-cycle ready answers every enable pulse
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_drdy <= 1'b0;
      o_do   <= 16'h0000;
    end
    else
    begin
      o_drdy <= i_den; // [RULE13]
      if (i_den && !i_dwe)
        o_do <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// [hdl/asq_top.sv]
// Function
// [RULE1] Sequence converts channels 8, 0, 1, 2, 3, 6, 10..13 in that order.
// [RULE2] Continuous mode restarts at the first entry right after the last channel.
// [RULE3] Five-bit channel bus shows the channel under conversion for its whole slot.
// [RULE4] Calibration slot performs three conversions, so lasts three times longer.
// [RULE5] Averaging select bits 00 in configuration register 0 turn averaging off.
// [RULE6] Port master writes configuration only after reset has been released.
// [RULE7] End-of-sequence strobe is high one port-clock cycle per pass.
// [RULE8] Port master reads result registers after seeing end-of-sequence.
// [RULE9] Result registers hold the result left-justified; low four bits extend it.
// [RULE10] Ideal model fills all sixteen result bits with the exact value.
// [RULE11] Channel alarm updates when that channel's result is loaded.
// [RULE12] Auxiliary-supply alarm goes high when its result exceeds the upper threshold.
// [RULE13] Enable pulse for one cycle; ready answers one cycle later with read data.
`timescale 1ns/10ps
`default_nettype none
`include "asq_map.svh"
module asq_top
#(
  parameter int CONV_CYCLES = `ASQ_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Reconfiguration port
  input  wire logic               i_den,
  input  wire logic               i_dwe,
  input  wire asq_pkg::asq_addr_t i_daddr,
  input  wire asq_pkg::asq_word_t i_di,
  output var  asq_pkg::asq_word_t o_do,
  output var  logic               o_drdy,
  // Converter front end
  input  wire asq_pkg::asq_word_t i_conv_data,
  // Status
  output var  asq_pkg::asq_chan_t o_channel,
  output var  logic               o_eoc,
  output var  logic               o_eos,
  output var  logic [3:0]         o_alarm
);
  import asq_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES);

  // Counter width and slot logic need at least two cycles per conversion
  if (CONV_CYCLES < 2)
  begin : g_bad_cycles
    $error("CONV_CYCLES must be at least 2");
  end

  function automatic asq_chan_t seq_chan(input logic [3:0] idx);
    asq_chan_t c;
    c = `ASQ_CH_CAL;
    unique case (idx)
      4'h0: c = `ASQ_CH_CAL;
      4'h1: c = `ASQ_CH_TEMP;
      4'h2: c = `ASQ_CH_VINT;
      4'h3: c = `ASQ_CH_VAUX;
      4'h4: c = `ASQ_CH_VPN; // [RULE1]
      4'h5: c = `ASQ_CH_VBRAM;
      4'h6: c = `ASQ_CH_AUX0;
      4'h7: c = `ASQ_CH_AUX1;
      4'h8: c = `ASQ_CH_AUX2;
      4'h9: c = `ASQ_CH_AUX3;
      default: c = `ASQ_CH_CAL;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] alm_sel(input asq_chan_t c);
    logic [3:0] s;
    s = 4'h0;
    if (c == `ASQ_CH_TEMP)  s[`ASQ_ALM_TEMP]  = 1'b1;
    if (c == `ASQ_CH_VINT)  s[`ASQ_ALM_VINT]  = 1'b1;
    if (c == `ASQ_CH_VAUX)  s[`ASQ_ALM_VAUX]  = 1'b1;
    if (c == `ASQ_CH_VBRAM) s[`ASQ_ALM_VBRAM] = 1'b1;
    return s;
  endfunction

  // Successor channel, kept apart from the slot table so the order check stands alone
  function automatic asq_chan_t seq_next(input asq_chan_t c);
    asq_chan_t n;
    n = `ASQ_CH_CAL;
    unique case (c)
      `ASQ_CH_CAL:   n = `ASQ_CH_TEMP;
      `ASQ_CH_TEMP:  n = `ASQ_CH_VINT;
      `ASQ_CH_VINT:  n = `ASQ_CH_VAUX;
      `ASQ_CH_VAUX:  n = `ASQ_CH_VPN;
      `ASQ_CH_VPN:   n = `ASQ_CH_VBRAM;
      `ASQ_CH_VBRAM: n = `ASQ_CH_AUX0;
      `ASQ_CH_AUX0:  n = `ASQ_CH_AUX1;
      `ASQ_CH_AUX1:  n = `ASQ_CH_AUX2;
      `ASQ_CH_AUX2:  n = `ASQ_CH_AUX3;
      `ASQ_CH_AUX3:  n = `ASQ_CH_CAL;
      default:       n = `ASQ_CH_CAL;
    endcase
    return n;
  endfunction

  asq_res_if res ();

  asq_state_t     st_r;
  logic [CW-1:0]  cnt_r;
  logic [3:0]     idx_r;
  asq_word_t      acc_r [0:`ASQ_SEQ_LEN-1];
  logic           ld_r;
  asq_chan_t      ld_addr_r;
  asq_word_t      ld_data_r;
  logic           conv_end;
  logic           slot_end;
  logic           last_slot;
  logic [3:0]     idx_nxt;
  logic [16:0]    avg_sum;
  asq_word_t      res_nxt;
  logic [3:0]     alm_hit;

  assign conv_end  = (cnt_r == CW'(CONV_CYCLES - 1));
  assign slot_end  = conv_end && ((st_r == ST_CAL2) || (st_r == ST_CONV));
  assign last_slot = (idx_r == `ASQ_SEQ_LAST);
  assign idx_nxt   = last_slot ? 4'h0 : idx_r + 4'h1; // [RULE2]
  assign avg_sum   = {1'b0, acc_r[idx_r]} + {1'b0, i_conv_data};
  // Averaging off passes the full 16-bit value through untouched
  assign res_nxt   = (res.cfg_avg == `ASQ_AVG_OFF) ? i_conv_data : avg_sum[16:1]; // [RULE5]
  assign alm_hit   = alm_sel(ld_addr_r);

  assign res.ld      = ld_r;
  assign res.ld_addr = ld_addr_r;
  assign res.ld_data = ld_data_r;

  // Conversion timer
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || conv_end)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CW'(1);
  end

  // Slot sequencing
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      st_r      <= ST_CAL0;
      idx_r     <= 4'h0;
      o_channel <= `ASQ_CH_CAL;
    end
    else if (conv_end)
    begin
      unique case (st_r)
        ST_CAL0: st_r <= ST_CAL1; // [RULE4]
        ST_CAL1: st_r <= ST_CAL2; // [RULE4]
        ST_CAL2: st_r <= ST_CONV;
        ST_CONV: st_r <= last_slot ? ST_CAL0 : ST_CONV; // [RULE2]
      endcase
      if (slot_end)
      begin
        idx_r     <= idx_nxt;
        o_channel <= seq_chan(idx_nxt); // [RULE1] [RULE3]
      end
    end
  end

  // Result loading and strobes
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ld_r      <= 1'b0;
      ld_addr_r <= `ASQ_CH_CAL;
      ld_data_r <= 16'h0000;
      o_eoc     <= 1'b0;
      o_eos     <= 1'b0;
    end
    else
    begin
      ld_r  <= slot_end;
      o_eoc <= slot_end;
      o_eos <= slot_end && last_slot; // [RULE7]
      if (slot_end)
      begin
        ld_addr_r <= o_channel;
        ld_data_r <= res_nxt; // [RULE9] [RULE10]
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (slot_end)
      acc_r[idx_r] <= res_nxt;
  end

  // One comparator per supervised channel
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_alm
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
          o_alarm[g] <= 1'b0;
        else if (ld_r && alm_hit[g])
          o_alarm[g] <= (ld_data_r > res.thr[g]); // [RULE11] [RULE12]
      end
    end
  endgenerate

  asq_regs u_regs
  (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_den   (i_den),
    .i_dwe   (i_dwe),
    .i_daddr (i_daddr),
    .i_di    (i_di),
    .o_do    (o_do),
    .o_drdy  (o_drdy),
    .res     (res.regs)
  );

  // Slot length observer for checks
  logic [15:0] len_r;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      len_r <= 16'h0001;
    else if (o_eoc)
      len_r <= 16'h0002;
    else
      len_r <= len_r + 16'h0001;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  eos_one_cycle_a: assert property (o_eos |=> !o_eos) // [RULE7]
    else $error("end-of-sequence longer than one cycle");
  eos_wraps_a: assert property (o_eos |-> o_channel == `ASQ_CH_CAL && o_eoc) // [RULE2]
    else $error("sequence did not restart at calibration");
  seq_order_a: assert property (o_eoc |-> o_channel == seq_next($past(o_channel))) // [RULE1]
    else $error("channel order wrong");
  chan_hold_a: assert property ($changed(o_channel) |-> o_eoc) // [RULE3]
    else $error("channel changed mid-conversion");
  cal_slot_a: assert property (o_eoc && $past(o_channel) == `ASQ_CH_CAL
                               |-> $past(len_r) == 16'(3 * CONV_CYCLES)) // [RULE4]
    else $error("calibration slot length wrong");
  avg_off_a: assert property (slot_end && res.cfg_avg == `ASQ_AVG_OFF
                              |=> ld_r && ld_data_r == $past(i_conv_data)) // [RULE5]
    else $error("unaveraged result differs from sample");
  alarm_time_a: assert property ($changed(o_alarm) |-> $past(ld_r)) // [RULE11]
    else $error("alarm changed without a result load");
  aux_alarm_a: assert property (ld_r && ld_addr_r == `ASQ_CH_VAUX
      |=> o_alarm[`ASQ_ALM_VAUX] == ($past(ld_data_r) > $past(res.thr[`ASQ_ALM_VAUX]))) // [RULE12]
    else $error("auxiliary supply alarm wrong");
  drdy_a: assert property (o_drdy == $past(i_den)) // [RULE13]
    else $error("ready did not follow enable");

  eos_seen_c: cover property (o_eos);
  vaux_alarm_c: cover property ($rose(o_alarm[`ASQ_ALM_VAUX]));
  cfg_write_c: cover property (i_den && i_dwe && i_daddr == `ASQ_CFG0_ADDR);
endmodule
`default_nettype wire

// [tb/asq_port_master.sv]
`timescale 1ns/10ps
`default_nettype none
module asq_port_master
(
  // Clock
  input  wire logic               i_mclk,
  // Reconfiguration port
  output var  logic               o_den,
  output var  logic               o_dwe,
  output var  asq_pkg::asq_addr_t o_daddr,
  output var  asq_pkg::asq_word_t o_di,
  input  wire logic               i_drdy
);
  import asq_pkg::*;

  initial
  begin
    o_den   = 1'b0;
    o_dwe   = 1'b0;
    o_daddr = 7'h7f;
    o_di    = 16'hffff;
  end

  // Enable for one cycle, address held until ready, then lines scrambled
  task automatic access(input logic we, input asq_addr_t a, input asq_word_t d,
                        output logic ok);
    int i;
    @(negedge i_mclk);
    o_den   = 1'b1;
    o_dwe   = we;
    o_daddr = a;
    o_di    = d;
    @(negedge i_mclk);
    o_den   = 1'b0;
    o_dwe   = 1'b0;
    for (i = 0; i < 4 && i_drdy !== 1'b1; i++)
      @(negedge i_mclk);
    ok      = (i < 4);
    o_daddr = ~a;
    o_di    = ~d;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "asq_map.svh"
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
      n_mismatch++; \
    end \
  end
module tb;
  import asq_pkg::*;
  localparam int N = 6;
  localparam asq_chan_t SEQ [10] = '{5'h08, 5'h00, 5'h01, 5'h02, 5'h03, 5'h06,
                                     5'h10, 5'h11, 5'h12, 5'h13};
  logic        clk, rst_n, den, dwe, drdy, eoc, eos, eoc_d, den_q, ok, avg_on;
  logic [3:0]  alm, alm_q, a;
  asq_addr_t   addr;
  asq_word_t   di, dout, conv;
  asq_chan_t   ch, ld_ch;
  asq_word_t   exp_res [32];
  asq_word_t   thr [4];
  logic [16:0] sb [$];
  logic [16:0] e;
  int          n_mismatch, tests_run, idx, cnt, k;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  asq_top #(.CONV_CYCLES(N)) DUT
  (
    .i_mclk(clk), .i_rst_n(rst_n), .i_den(den), .i_dwe(dwe), .i_daddr(addr),
    .i_di(di), .o_do(dout), .o_drdy(drdy), .i_conv_data(conv), .o_channel(ch),
    .o_eoc(eoc), .o_eos(eos), .o_alarm(alm)
  );

  asq_port_master PM
  (
    .i_mclk(clk), .o_den(den), .o_dwe(dwe), .o_daddr(addr), .o_di(di), .i_drdy(drdy)
  );

  task end_sim;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Notes the expected answer, then runs the access
  task acc(input logic we, input asq_addr_t ad, input asq_word_t d, input asq_word_t ev);
    sb.push_back({!we, ev});
    PM.access(we, ad, d, ok);
    if (!ok)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  always @(posedge clk)
    den_q <= den;

  // Output watcher; also holds the converter input steady for each slot
  always @(negedge clk)
  begin
    if (!rst_n)
    begin
      idx   = 0;
      cnt   = -999;
      eoc_d = 1'b0;
      alm_q = 4'h0;
    end
    else
    begin
      `CHK("drdy", den_q, drdy)
      if (drdy === 1'b1)
      begin
        if (sb.size() == 0)
          `CHK("queue", 1'b1, 1'b0)
        else
        begin
          e = sb.pop_front();
          if (e[16])
            `CHK("do", e[15:0], dout)
        end
      end
      a = alm_q;
      if (eoc_d)
      begin
        k = (ld_ch == `ASQ_CH_VBRAM) ? 3 : ((ld_ch < 5'h03) ? int'(ld_ch) : 9);
        if (k < 4)
          a[k] = exp_res[ld_ch] > thr[k];
      end
      `CHK("alarm", a, alm)
      alm_q = a;
      `CHK("eos", (eoc === 1'b1) && (SEQ[idx] == `ASQ_CH_AUX3), eos)
      eoc_d = (eoc === 1'b1);
      if (eoc_d)
      begin
        if (cnt > 0)
          `CHK("slot", (SEQ[idx] == `ASQ_CH_CAL) ? 3 * N : N, cnt)
        ld_ch          = SEQ[idx];
        if (avg_on)
          exp_res[ld_ch] = 16'(({1'b0, exp_res[ld_ch]} + {1'b0, conv}) >> 1);
        else
          exp_res[ld_ch] = conv;
        conv           = 16'($urandom);
        idx            = (idx + 1) % 10;
        cnt            = 1;
      end
      else
        cnt++;
      `CHK("channel", SEQ[idx], ch)
    end
  end

  initial
  begin
    int        p;
    int        i;
    asq_word_t w;
    rst_n      = 1'b0;
    conv       = 16'h0000;
    avg_on     = 1'b0;
    n_mismatch = 0;
    tests_run  = 0;
    thr[0]     = `ASQ_THR_TEMP_RST;
    thr[1]     = `ASQ_THR_VINT_RST;
    thr[2]     = `ASQ_THR_VAUX_RST;
    thr[3]     = `ASQ_THR_VBRAM_RST;
    void'($urandom(8));
    repeat (2) @(negedge clk);
    `CHK("rst channel", `ASQ_CH_CAL, ch)
    `CHK("rst eos", 1'b0, eos)
    `CHK("rst alarm", 4'h0, alm)
    rst_n = 1'b1;
    acc(1'b0, `ASQ_CFG0_ADDR, 16'h0000, `ASQ_CFG0_RST);
    acc(1'b1, `ASQ_CFG0_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, `ASQ_CFG0_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, `ASQ_THR_TEMP_ADDR, 16'h0000, `ASQ_THR_TEMP_RST);
    acc(1'b0, `ASQ_THR_VINT_ADDR, 16'h0000, `ASQ_THR_VINT_RST);
    acc(1'b0, `ASQ_THR_VAUX_ADDR, 16'h0000, `ASQ_THR_VAUX_RST);
    acc(1'b0, `ASQ_THR_VBRAM_ADDR, 16'h0000, `ASQ_THR_VBRAM_RST);
    acc(1'b0, 7'h60, 16'h0000, 16'h0000);
    for (p = 0; p < 4; p++)
    begin
      for (i = 0; i < 300 && eos !== 1'b1; i++)
        @(negedge clk);
      if (i == 300)
      begin
        n_mismatch++;
        end_sim();
      end
      // Result registers are read-only: this write must leave 00h alone
      acc(1'b1, 7'h00, 16'h1234, 16'h0000);
      if (p == 1)
      begin
        w = 16'($urandom);
        acc(1'b1, `ASQ_THR_VAUX_ADDR, w, 16'h0000);
        thr[2] = w;
        acc(1'b0, `ASQ_THR_VAUX_ADDR, 16'h0000, w);
      end
      if (p == 2)
      begin
        // Averaging on: the calibration slot now running is the first averaged one
        acc(1'b1, `ASQ_CFG0_ADDR, 16'h1000, 16'h0000);
        avg_on = 1'b1;
        acc(1'b0, `ASQ_CFG0_ADDR, 16'h0000, 16'h1000);
      end
      for (i = 0; i < 10; i++)
        acc(1'b0, {2'b00, SEQ[i]}, 16'h0000, exp_res[SEQ[i]]);
    end
    end_sim();
  end
endmodule
`default_nettype wire
